// file: logic/pps_steer.sv
// Pulse steering top: register file, steering sync, polarity, shutdown and pin control
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_steer (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [3:0]      addr,
	input  wire logic [7:0]      wdata,
	input  wire logic            wr,
	input  wire logic            rd,
	output logic [7:0]           rdata,
	input  wire pps_pkg::pps_pmode_t pmode,
	input  wire logic            fscm_enable,
	input  wire logic            primary_fail,
	input  wire logic            alt_clk_tick,
	input  wire logic            int_osc_tick,
	input  wire logic            shutdown_in,
	output logic [3:0]           pwm_out,
	output logic [3:0]           pwm_oe_n,
	output logic                 osc_fail_flag,
	output logic                 internal_osc_run_mode
);
	logic [7:0] steer_reg;
	logic [3:0] steer_act_reg;
	logic       pend_reg;
	logic [7:0] tcon_reg;
	logic [7:0] period_reg;
	logic [7:0] duty_lo_reg;
	logic [7:0] duty_hi_reg;
	logic [7:0] ccpcon_reg;
	logic [7:0] asd_reg;
	logic [7:0] dband_reg;
	logic [3:0] dir_reg;
	logic [3:0] port_reg;
	logic       fail_flag_reg;
	logic [7:0] rdata_reg;
	logic [3:0] out_reg;
	logic [3:0] oe_n_reg;
	logic       int_run_reg;

	logic       tick;
	logic       int_run;
	logic       fail_event;
	logic [7:0] count;
	logic       period_start;
	logic       pwm_raw;

	wire sleeping = (pmode == pps_pkg::PPS_PM_SLEEP);
	wire wr_steer = wr && (addr == `PPS_OFF_STEER);
	wire wr_tmr   = wr && (addr == `PPS_OFF_TMR);
	wire wr_tcon  = wr && (addr == `PPS_OFF_TCON);
	wire wr_per   = wr && (addr == `PPS_OFF_PERIOD);
	wire wr_dlo   = wr && (addr == `PPS_OFF_DUTY_LO);
	wire wr_dhi   = wr && (addr == `PPS_OFF_DUTY_HI);
	wire wr_ccp   = wr && (addr == `PPS_OFF_CCPCON);
	wire wr_asd   = wr && (addr == `PPS_OFF_ASD);
	wire wr_dband = wr && (addr == `PPS_OFF_DBAND);
	wire wr_dir   = wr && (addr == `PPS_OFF_DIR);
	wire wr_port  = wr && (addr == `PPS_OFF_PORT);
	wire wr_stat  = wr && (addr == `PPS_OFF_STATUS);

	wire tmr_on   = tcon_reg[`PPS_BIT_TMR_ON];

	wire steer_mode = (ccpcon_reg[3:2] == 2'h3) && (ccpcon_reg[7:6] == 2'h0);

	// Polarity: bit 0 inverts pins 1 and 3, bit 1 inverts pins 0 and 2
	wire [3:0] pol_inv = {ccpcon_reg[0], ccpcon_reg[1], ccpcon_reg[0], ccpcon_reg[1]};

	pps_tick_sel u_tick (
		.clk          (clk),
		.rst          (rst),
		.pmode        (pmode),
		.fscm_enable  (fscm_enable),
		.primary_fail (primary_fail),
		.alt_clk_tick (alt_clk_tick),
		.int_osc_tick (int_osc_tick),
		.tick         (tick),
		.int_run_mode (int_run),
		.fail_event   (fail_event)
	);

	pps_pwm_core u_core (
		.clk          (clk),
		.rst          (rst),
		.tick         (tick),
		.run          (tmr_on),
		.tmr_wr       (wr_tmr),
		.tmr_wdata    (wdata),
		.period       (period_reg),
		.duty         ({duty_lo_reg, ccpcon_reg[5:4]}),
		.count        (count),
		.period_start (period_start),
		.pwm_raw      (pwm_raw)
	);

	wire       commit_now  = wr_steer && !wdata[`PPS_BIT_SYNC];
	wire       commit_sync = pend_reg && period_start;
	wire [3:0] steer_next  = commit_now ? wdata[3:0] : steer_reg[3:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			steer_reg     <= `PPS_STEER_RST;
			steer_act_reg <= 4'(`PPS_STEER_RST);
			pend_reg      <= 1'b0;
		end else begin
			if (wr_steer)
				steer_reg <= wdata & `PPS_STEER_MASK;
			if (commit_now || commit_sync)
				steer_act_reg <= steer_next;
			if (wr_steer)
				pend_reg <= wdata[`PPS_BIT_SYNC];
			else if (commit_sync)
				pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tcon_reg    <= 8'h00;
			period_reg  <= `PPS_PERIOD_RST;
			duty_lo_reg <= 8'h00;
			duty_hi_reg <= 8'h00;
			ccpcon_reg  <= 8'h00;
			dband_reg   <= 8'h00;
			dir_reg     <= `PPS_DIR_RST;
			port_reg    <= 4'h0;
		end else begin
			if (wr_tcon)
				tcon_reg <= wdata & `PPS_TCON_MASK;
			if (wr_per)
				period_reg <= wdata;
			if (wr_dlo)
				duty_lo_reg <= wdata;
			if (wr_dhi)
				duty_hi_reg <= wdata;
			if (wr_ccp)
				ccpcon_reg <= wdata;
			if (wr_dband)
				dband_reg <= wdata;
			if (wr_dir)
				dir_reg <= wdata[3:0];
			if (wr_port)
				port_reg <= wdata[3:0];
		end
	end

	// Shutdown flag: hardware set wins over a software clear in the same cycle
	wire asd_set = shutdown_in && steer_mode;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			asd_reg <= 8'h00;
		else if (asd_set)
			asd_reg <= wr_asd ? (wdata | 8'h80) : (asd_reg | 8'h80);
		else if (wr_asd)
			asd_reg <= wdata;
	end

	// fail flag, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fail_flag_reg <= 1'b0;
		else if (fail_event)
			fail_flag_reg <= 1'b1;
		else if (wr_stat && !wdata[`PPS_BIT_OSC_FAIL])
			fail_flag_reg <= 1'b0;
	end

	wire shut_active = asd_reg[`PPS_BIT_ASE];

	genvar i;
	wire [3:0] pin_level;
	wire [3:0] pin_pwm;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_pin
			assign pin_pwm[i] = steer_mode && steer_act_reg[i];
			assign pin_level[i] = pin_pwm[i]
				? (shut_active ? 1'b0 : (pwm_raw ^ pol_inv[i]))
				: port_reg[i];
		end
	endgenerate

	// pin outputs frozen in sleep, int_run_reg still updates; direction bits gate the drivers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_reg     <= 4'h0;
			oe_n_reg    <= 4'hf;
			int_run_reg <= 1'b0;
		end else begin
			int_run_reg <= int_run;
			if (!sleeping) begin
				out_reg  <= pin_level;
				oe_n_reg <= dir_reg;
			end
		end
	end

	wire [7:0] status_word = {6'h00, int_run_reg, fail_flag_reg};
	wire [7:0] rd_mux =
		(addr == `PPS_OFF_STEER)   ? steer_reg :
		(addr == `PPS_OFF_TMR)     ? count :
		(addr == `PPS_OFF_TCON)    ? tcon_reg :
		(addr == `PPS_OFF_PERIOD)  ? period_reg :
		(addr == `PPS_OFF_DUTY_LO) ? duty_lo_reg :
		(addr == `PPS_OFF_DUTY_HI) ? duty_hi_reg :
		(addr == `PPS_OFF_CCPCON)  ? ccpcon_reg :
		(addr == `PPS_OFF_ASD)     ? asd_reg :
		(addr == `PPS_OFF_DBAND)   ? dband_reg :
		(addr == `PPS_OFF_DIR)     ? {4'h0, dir_reg} :
		(addr == `PPS_OFF_STATUS)  ? status_word :
		(addr == `PPS_OFF_PORT)    ? {4'h0, port_reg} : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (rd)
			rdata_reg <= rd_mux;
		else
			rdata_reg <= 8'h00;
	end

	assign rdata                 = rdata_reg;
	assign pwm_out               = out_reg;
	assign pwm_oe_n              = oe_n_reg;
	assign osc_fail_flag         = fail_flag_reg;
	assign internal_osc_run_mode = int_run_reg;
endmodule

// file: shared/pps_defs.svh
// Register offsets, field positions, reset values and behaviour notes for the pulse steering block
// Notes on behaviour
// - A set steering enable drives its pin with the shared PWM, polarity from mode bits 1:0.
// - A clear steering enable hands the pin back to ordinary port use.
// - Steering works only with mode bits 3:2 = 11 and output config = 00.
// - Sync select 0 applies a steering write at once, even mid pulse.
// - Sync select 1 holds a steering write until the next PWM period start.
// - In sleep the period timer stops, PWM state freezes and pins keep their level.
// - Idle and run modes clock the period timer on every clock, alt-clock mode on alt_clk_tick; internal-osc run overrides all three with int_osc_tick.
// - A primary clock fail under monitoring enters internal-osc run and sets the fail flag.
// - Reset makes all pins inputs and all registers take their reset values.
// - Auto-shutdown acts only on steered pins; unsteered pins are untouched.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

`define PPS_OFF_STEER      4'h0
`define PPS_OFF_TMR        4'h1
`define PPS_OFF_TCON       4'h2
`define PPS_OFF_PERIOD     4'h3
`define PPS_OFF_DUTY_LO    4'h4
`define PPS_OFF_DUTY_HI    4'h5
`define PPS_OFF_CCPCON     4'h6
`define PPS_OFF_ASD        4'h7
`define PPS_OFF_DBAND      4'h8
`define PPS_OFF_DIR        4'h9
`define PPS_OFF_STATUS     4'ha
`define PPS_OFF_PORT       4'hb

`define PPS_STEER_RST      8'h01
`define PPS_STEER_MASK     8'h1f
`define PPS_BIT_SYNC       4
`define PPS_DIR_RST        4'hf
`define PPS_PERIOD_RST     8'hff
`define PPS_TCON_MASK      8'h7f
`define PPS_BIT_TMR_ON     2
`define PPS_BIT_ASE        7
`define PPS_BIT_OSC_FAIL   0
`define PPS_BIT_INT_RUN    1

`endif

// file: shared/pps_pkg.sv
// Types for the pulse steering block
package pps_pkg;
	typedef enum logic [1:0] {
		PPS_PM_RUN,
		PPS_PM_PRIMARY_IDLE_MODE,
		PPS_PM_ALT_CLK,
		PPS_PM_SLEEP
	} pps_pmode_t;

	typedef enum logic [1:0] {
		PPS_CLK_PRIMARY,
		PPS_CLK_INT_RUN
	} pps_clk_state_t;
endpackage

// file: logic/pps_tick_sel.sv
// Period timer tick source selection across power modes and clock failure
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_tick_sel (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire pps_pkg::pps_pmode_t pmode,
	input  wire logic            fscm_enable,
	input  wire logic            primary_fail,
	input  wire logic            alt_clk_tick,
	input  wire logic            int_osc_tick,
	output logic                 tick,
	output logic                 int_run_mode,
	output logic                 fail_event
);
	pps_pkg::pps_clk_state_t state_reg;
	pps_pkg::pps_clk_state_t state_next;

	wire fail_hit = fscm_enable && primary_fail && (state_reg == pps_pkg::PPS_CLK_PRIMARY);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pps_pkg::PPS_CLK_PRIMARY: begin
				if (fail_hit)
					state_next = pps_pkg::PPS_CLK_INT_RUN;
			end
			pps_pkg::PPS_CLK_INT_RUN: begin
				if (!primary_fail)
					state_next = pps_pkg::PPS_CLK_PRIMARY;
			end
			default: state_next = pps_pkg::PPS_CLK_PRIMARY;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_reg <= pps_pkg::PPS_CLK_PRIMARY;
		else
			state_reg <= state_next;
	end

	assign int_run_mode = (state_reg == pps_pkg::PPS_CLK_INT_RUN);
	assign fail_event   = fail_hit;

	always_comb begin
		if (pmode == pps_pkg::PPS_PM_SLEEP)
			tick = 1'b0;
		else if (int_run_mode)
			tick = int_osc_tick;
		else if (pmode == pps_pkg::PPS_PM_ALT_CLK)
			tick = alt_clk_tick;
		else
			tick = 1'b1;
	end
endmodule

// file: logic/pps_pwm_core.sv
// Period timer and duty compare producing the raw PWM waveform
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_pwm_core (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic        tmr_wr,
	input  wire logic [7:0]  tmr_wdata,
	input  wire logic [7:0]  period,
	input  wire logic [9:0]  duty,
	output logic [7:0]       count,
	output logic             period_start,
	output logic             pwm_raw
);
	logic [9:0] fine_reg;
	logic [9:0] duty_reg;
	logic       raw_reg;

	wire at_match  = (fine_reg[9:2] == period) && (fine_reg[1:0] == 2'h3);
	wire step      = tick && run;
	wire [9:0] fine_inc = fine_reg + 10'h001;

	assign count        = fine_reg[9:2];
	assign period_start = step && at_match;
	assign pwm_raw      = raw_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fine_reg <= 10'h000;
			duty_reg <= 10'h000;
			raw_reg  <= 1'b0;
		end else if (tmr_wr) begin
			fine_reg <= {tmr_wdata, 2'h0};
		end else if (period_start) begin
			fine_reg <= 10'h000;
			duty_reg <= duty;
			raw_reg  <= (duty != 10'h000);
		end else if (step) begin
			fine_reg <= fine_inc;
			if (fine_inc == duty_reg)
				raw_reg <= 1'b0;
		end
	end
endmodule

// file: testbench/pps_steer_checker.sv
// Port assertions for the pulse steering block
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_steer_checker (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic [3:0]	addr,
	input wire logic [7:0]	wdata,
	input wire logic	wr,
	input wire logic	rd,
	input wire logic [7:0]	rdata,
	input wire pps_pkg::pps_pmode_t	pmode,
	input wire logic	fscm_enable,
	input wire logic	primary_fail,
	input wire logic	shutdown_in,
	input wire logic [3:0]	pwm_out,
	input wire logic [3:0]	pwm_oe_n,
	input wire logic	osc_fail_flag,
	input wire logic	internal_osc_run_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic		in_sleep = pmode == pps_pkg::PPS_PM_SLEEP;
	wire logic [3:0]	wlow = wdata[3:0];
	wire logic		fail_on = fscm_enable && primary_fail;
	AST_RDATA_IDLE:
		assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	AST_UNMAPPED_ZERO:
		assert property ($past(rd) && $past(addr) > 4'hb |-> rdata == 8'h00) else $error("unmapped read");
	AST_STEER_RSV:
		assert property ($past(rd) && $past(addr) == 4'h0 |-> rdata[7:5] == 3'h0) else $error("reserved bits");
	AST_DIR_TO_OE:
		assert property (wr && addr == `PPS_OFF_DIR && !in_sleep ##1 !in_sleep |=> pwm_oe_n == $past(wlow, 2))
		else $error("oe_n not from direction");
	AST_FAIL_FLAG:
		assert property (fail_on |-> ##[1:3] osc_fail_flag) else $error("fail flag late");
	AST_INT_RUN:
		assert property (fail_on |-> ##[1:3] internal_osc_run_mode) else $error("internal run late");
	AST_FAIL_CAUSE:
		assert property ($rose(osc_fail_flag) |-> $past(fail_on)) else $error("fail flag without cause");
	AST_SLEEP_FROZEN:
		assert property ($past(in_sleep) |-> $stable(pwm_out) && $stable(pwm_oe_n)) else $error("pins moved");
	AST_FLAG_CLEAR:
		assert property (wr && addr == `PPS_OFF_STATUS && !wdata[0] && !primary_fail |-> ##[1:2] !osc_fail_flag)
		else $error("fail flag kept");
	COV_SLEEP: cover property (in_sleep ##1 !in_sleep);
	COV_FAIL: cover property ($rose(osc_fail_flag));
	COV_SHUT: cover property (shutdown_in ##1 !shutdown_in);
	COV_ALT: cover property (pmode == pps_pkg::PPS_PM_ALT_CLK ##1 pmode == pps_pkg::PPS_PM_RUN);
endmodule
bind pps_steer pps_steer_checker u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .pmode(pmode), .fscm_enable(fscm_enable), .primary_fail(primary_fail),
	.shutdown_in(shutdown_in), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .osc_fail_flag(osc_fail_flag),
	.internal_osc_run_mode(internal_osc_run_mode));

// file: testbench/pps_load_model.sv
// Load on the four output pins
`timescale 1ns/1ps
module pps_load_model (
	input wire logic [3:0]	pwm_out,
	input wire logic [3:0]	pwm_oe_n,
	output logic [3:0]	pin_level
);
	// driver needs direction cleared
	// An undriven pin is pulled low by the load, never left at its last level
	assign pin_level = pwm_out & ~pwm_oe_n;
endmodule

// file: testbench/test_pps_steer.sv
// Self-checking bench for the pulse steering block
`timescale 1ns/1ps
`include "pps_defs.svh"
module test_pps_steer;
	logic	clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic	fscm_enable = 1'b0, primary_fail = 1'b0, shutdown_in = 1'b0;
	logic	alt_clk_tick = 1'b0, int_osc_tick = 1'b0;
	logic [3:0]	addr = 4'h0, pwm_out, pwm_oe_n, pin_level;
	logic [7:0]	wdata = 8'h00, rdata, v;
	logic	osc_fail_flag, internal_osc_run_mode;
	pps_pkg::pps_pmode_t	pmode = pps_pkg::PPS_PM_RUN;
	int	n_mismatch = 0, n_compared = 0;
	always #5 clk = ~clk;
	pps_steer DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pmode(pmode), .fscm_enable(fscm_enable), .primary_fail(primary_fail), .alt_clk_tick(alt_clk_tick),
		.int_osc_tick(int_osc_tick), .shutdown_in(shutdown_in), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
		.osc_fail_flag(osc_fail_flag), .internal_osc_run_mode(internal_osc_run_mode));
	pps_load_model LOAD (.pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .pin_level(pin_level));
	task automatic close_out;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cp(input logic [3:0] e);
		chk({4'h0, pwm_out}, {4'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Idle cycle after each write so wr is never lowered and raised in one step
	task automatic bw(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic br(input logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		br(a);
		chk(v, e);
	endtask
	task automatic wait_pins(input logic [3:0] e);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pwm_out === e) return;
		end
		n_mismatch++;
		$display("CHECK FAILED %0t pins stuck", $time);
		close_out;
	endtask
	task automatic t_reset;
		rc(4'h0, `PPS_STEER_RST);
		rc(4'h3, `PPS_PERIOD_RST);
		rc(4'h9, {4'h0, `PPS_DIR_RST});
		rc(4'hc, 8'h00);
		chk({4'h0, pwm_oe_n}, 8'h0f);
		bw(4'h0, 8'hef);
		rc(4'h0, 8'h0f);
	endtask
	task automatic t_route;
		logic [7:0] m [6] = '{8'h0c, 8'h0d, 8'h0e, 8'h4f, 8'h0b, 8'h0f};
		logic [3:0] e [6] = '{4'h0, 4'ha, 4'h5, 4'h0, 4'h0, 4'hf};
		bw(4'h9, 8'h00);
		for (int i = 0; i < 6; i++) begin
			bw(4'h6, m[i]);
			cyc(1);
			cp(e[i]);
		end
		bw(4'hb, 8'h0a);
		bw(4'h0, 8'h05);
		cyc(1);
		chk({4'h0, pin_level}, 8'h0f);
		bw(4'h9, 8'h05);
		cyc(1);
		chk({4'h0, pin_level}, 8'h0a);
		bw(4'h9, 8'h00);
	endtask
	task automatic t_sync;
		bw(4'h6, 8'h0c);
		bw(4'hb, 8'h0f);
		bw(4'h0, 8'h0f);
		wait_pins(4'h0);
		bw(4'h0, 8'h11);
		rc(4'h0, 8'h11);
		cyc(4);
		cp(4'h0);
		bw(4'h3, 8'h00);
		bw(4'h2, 8'h04);
		wait_pins(4'he);
	endtask
	task automatic t_shut;
		bw(4'h6, 8'h0f);
		bw(4'h0, 8'h03);
		wait_pins(4'hf);
		shutdown_in <= 1'b1;
		wait_pins(4'hc);
		rc(4'h7, 8'h80);
		shutdown_in <= 1'b0;
		bw(4'h7, 8'h00);
		wait_pins(4'hf);
	endtask
	task automatic t_sleep;
		logic [7:0] t;
		bw(4'h3, 8'hff);
		pmode <= pps_pkg::PPS_PM_SLEEP;
		br(4'h1);
		t = v;
		cyc(12);
		rc(4'h1, t);
		pmode <= pps_pkg::PPS_PM_RUN;
		cyc(12);
		br(4'h1);
		chk({7'h0, v > t}, 8'h01);
	endtask
	task automatic t_fail;
		fscm_enable <= 1'b1;
		primary_fail <= 1'b1;
		cyc(4);
		chk({6'h0, osc_fail_flag, internal_osc_run_mode}, 8'h03);
		rc(4'ha, 8'h03);
		primary_fail <= 1'b0;
		cyc(4);
		chk({7'h0, internal_osc_run_mode}, 8'h00);
		bw(4'ha, 8'h00);
		chk({7'h0, osc_fail_flag}, 8'h00);
	endtask
	// Timer byte counts fine steps of four; a write resets the fine phase
	task automatic t_clk;
		pmode <= pps_pkg::PPS_PM_PRIMARY_IDLE_MODE;
		bw(4'h1, 8'h10);
		cyc(7);
		rc(4'h1, 8'h12);
		pmode <= pps_pkg::PPS_PM_ALT_CLK;
		bw(4'h1, 8'h10);
		cyc(8);
		alt_clk_tick <= 1'b1;
		cyc(4);
		alt_clk_tick <= 1'b0;
		rc(4'h1, 8'h11);
		pmode <= pps_pkg::PPS_PM_RUN;
		primary_fail <= 1'b1;
		cyc(2);
		bw(4'h1, 8'h10);
		cyc(8);
		int_osc_tick <= 1'b1;
		cyc(4);
		int_osc_tick <= 1'b0;
		rc(4'h1, 8'h11);
		primary_fail <= 1'b0;
		cyc(4);
		bw(4'ha, 8'h00);
		chk({6'h0, osc_fail_flag, internal_osc_run_mode}, 8'h00);
	endtask
	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(1);
		t_reset();
		t_route();
		t_sync();
		t_shut();
		t_sleep();
		t_fail();
		t_clk();
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		chk({pwm_oe_n, pwm_out}, 8'hf0);
		rc(4'h0, `PPS_STEER_RST);
		close_out();
	end
endmodule
